// ---- common/adc_seq_pkg.sv ----
package adc_seq_pkg;

	// ****************************************
	// control byte layout
	// ****************************************
	localparam int CTRL_W      = 8;
	localparam int PWR_HI_BIT  = 7;
	localparam int PWR_LO_BIT  = 6;
	localparam int ACQ_BIT     = 5;
	localparam int SGL_BIT     = 4;
	localparam int UNI_BIT     = 3;
	localparam int ADDR_MSB    = 2;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 8'hD8;

	typedef enum logic [1:0] {
		PWR_FULL_DOWN = 2'h0,
		PWR_STANDBY   = 2'h1,
		PWR_NORM_INT  = 2'h2,
		PWR_NORM_EXT  = 2'h3
	} pwr_sel_t;

	typedef enum logic [2:0] {
		ST_POR      = 3'h0,
		ST_IDLE     = 3'h1,
		ST_ACQ      = 3'h2,
		ST_CONV     = 3'h3,
		ST_STANDBY  = 3'h4,
		ST_SHUTDOWN = 3'h5
	} seq_state_t;

	// ****************************************
	// data widths and timing
	// ****************************************
	localparam int RESULT_W    = 10;
	localparam int SAMPLE_W    = 12;
	localparam int NUM_INPUTS  = 8;
	localparam int FIFO_DEPTH  = 32;
	localparam int ACQ_CYCLES  = 3;
	localparam int CONV_CYCLES = 13;
	localparam int CNT_W       = 8;
	localparam int CLK_PERIOD_NS = 50;
	localparam int POR_TIME_NS   = 10000;
	localparam int POR_CYCLES    = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_EXT_NS     = 50000;
	localparam int SETTLE_EXT_CYCLES = SETTLE_EXT_NS / CLK_PERIOD_NS;

endpackage : adc_seq_pkg

// ---- src/adc_seq.sv ----
// ****************************************
// result fifo
// ****************************************
module result_fifo #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 32
) (
	// clock and reset
	input  wire logic             clk_sys_in,
	input  wire logic             rst_in,
	// fill side
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	// drain side
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic      [WIDTH-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr_r;
	logic [AW:0]      rd_ptr_r;
	logic             full;
	logic             empty;

	assign full          = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
	assign empty         = (wr_ptr_r == rd_ptr_r);
	assign in_ready_out  = !full;
	assign out_valid_out = !empty;
	assign out_data_out  = mem[rd_ptr_r[AW-1:0]];

	always_ff @(posedge clk_sys_in) begin
		if (in_valid_in && !full) begin
			mem[wr_ptr_r[AW-1:0]] <= in_data_in;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			wr_ptr_r <= '0;
		end else if (in_valid_in && !full) begin
			wr_ptr_r <= wr_ptr_r + 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			rd_ptr_r <= '0;
		end else if (out_ready_in && !empty) begin
			rd_ptr_r <= rd_ptr_r + 1'b1;
		end
	end
endmodule : result_fifo

// ****************************************
// converter control sequencer
// ****************************************
module adc_seq
	import adc_seq_pkg::*;
(
	// clock and reset
	input  wire logic                clk_sys_in,
	input  wire logic                rst_in,
	// parallel bus pins
	input  wire logic                cs_n_in,
	input  wire logic                wr_n_in,
	input  wire logic                rd_n_in,
	input  wire logic                high_byte_select_in,
	input  wire logic [CTRL_W-1:0]   data_in,
	output logic      [CTRL_W-1:0]   data_out,
	output logic                     data_oe_out,
	output logic                     conv_done_n_out,
	// external conversion clock pin
	input  wire logic                conv_clk_in,
	// sampled analog inputs, lsb = reference / 4096
	input  wire logic [SAMPLE_W-1:0] analog_inputs_in [NUM_INPUTS],
	input  wire logic [SAMPLE_W-1:0] common_in,
	// input mux and power status
	output logic      [2:0]          pos_channel_out,
	output logic      [2:0]          neg_channel_out,
	output logic                     neg_is_common_out,
	output logic                     standby_out,
	output logic                     shutdown_out
);
	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [CTRL_W-1:0]   data_m_r, data_s_r;
	logic [4:0]          ctl_m_r, ctl_s_r;
	logic [SAMPLE_W-1:0] ain_m_r [NUM_INPUTS];
	logic [SAMPLE_W-1:0] ain_s_r [NUM_INPUTS];
	logic [SAMPLE_W-1:0] com_m_r, com_s_r;
	logic                cs_s, wr_s, rd_s, hbe_s, cclk_s;
	logic                wr_q_r, rd_q_r, cclk_q_r;

	always_ff @(posedge clk_sys_in) begin
		ctl_m_r  <= {cs_n_in, wr_n_in, rd_n_in, high_byte_select_in, conv_clk_in};
		ctl_s_r  <= ctl_m_r;
		data_m_r <= data_in;
		data_s_r <= data_m_r;
		ain_m_r  <= analog_inputs_in;
		ain_s_r  <= ain_m_r;
		com_m_r  <= common_in;
		com_s_r  <= com_m_r;
	end

	assign {cs_s, wr_s, rd_s, hbe_s, cclk_s} = ctl_s_r;

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			wr_q_r   <= 1'b1;
			rd_q_r   <= 1'b1;
			cclk_q_r <= 1'b0;
		end else begin
			wr_q_r   <= wr_s;
			rd_q_r   <= rd_s;
			cclk_q_r <= cclk_s;
		end
	end

	logic wr_rise, rd_fall, rd_rise;
	// chip select gates every strobe, clock included
	assign wr_rise = !cs_s && wr_s && !wr_q_r;
	assign rd_fall = !cs_s && !rd_s && rd_q_r;
	assign rd_rise = !cs_s && rd_s && !rd_q_r;

	// ****************************************
	// control byte
	// ****************************************
	logic [CTRL_W-1:0] ctrl_r;
	logic              ext_clk_r;
	pwr_sel_t          pwr_sel;
	seq_state_t        state_r;
	logic              take_ctrl;

	assign pwr_sel   = pwr_sel_t'(ctrl_r[PWR_HI_BIT:PWR_LO_BIT]);
	assign take_ctrl = wr_rise && (state_r != ST_POR) && (state_r != ST_CONV);

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			ctrl_r <= CTRL_RESET;
		end else if (take_ctrl && !(state_r == ST_ACQ)) begin
			ctrl_r <= data_s_r;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			ext_clk_r <= 1'b1;
		end else if (take_ctrl && state_r != ST_ACQ && data_s_r[PWR_HI_BIT]) begin
			ext_clk_r <= data_s_r[PWR_LO_BIT];
		end
	end

	// ****************************************
	// input mux select
	// ****************************************
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			pos_channel_out   <= 3'h0;
			neg_channel_out   <= 3'h0;
			neg_is_common_out <= 1'b1;
		end else if (ctrl_r[SGL_BIT]) begin
			pos_channel_out   <= ctrl_r[ADDR_MSB:0];
			neg_channel_out   <= 3'h0;
			neg_is_common_out <= 1'b1;
		end else begin
			pos_channel_out   <= ctrl_r[ADDR_MSB:0];
			neg_channel_out   <= {ctrl_r[ADDR_MSB:1], !ctrl_r[0]};
			neg_is_common_out <= 1'b0;
		end
	end

	// ****************************************
	// quantiser
	// ****************************************
	logic signed [SAMPLE_W+1:0] diff;
	logic signed [SAMPLE_W+1:0] rounded;
	logic        [RESULT_W-1:0] code;

	always_comb begin
		diff = $signed({2'h0, ain_s_r[pos_channel_out]}) -
			$signed(neg_is_common_out ? {2'h0, com_s_r} : {2'h0, ain_s_r[neg_channel_out]});
		rounded = (diff + 14'sh0002) >>> 2;
		if (ctrl_r[UNI_BIT]) begin
			if (diff < 0) begin
				code = 10'h000;
			end else if (rounded > 14'sh03FF) begin
				code = 10'h3FF;
			end else begin
				code = rounded[RESULT_W-1:0];
			end
		end else begin
			if (rounded > 14'sh01FF) begin
				code = 10'h1FF;
			end else if (rounded < -14'sh0200) begin
				code = 10'h200;
			end else begin
				code = rounded[RESULT_W-1:0];
			end
		end
	end

	// ****************************************
	// sequencer
	// ****************************************
	logic [CNT_W-1:0]    cnt_r;
	logic [RESULT_W-1:0] hold_r;
	logic                tick;
	logic                push;
	logic                fifo_ready;

	// internal clock runs at the system rate
	assign tick = ext_clk_r ? (!cs_s && cclk_s && !cclk_q_r) : 1'b1;
	// a full fifo stalls the end of conversion
	assign push = (state_r == ST_CONV) && (cnt_r == CNT_W'(CONV_CYCLES)) && fifo_ready;

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			state_r <= ST_POR;
			cnt_r   <= '0;
		end else begin
			case (state_r)
				ST_POR: begin
					cnt_r <= cnt_r + 1'b1;
					if (cnt_r == CNT_W'(POR_CYCLES - 1)) begin
						state_r <= ST_IDLE;
						cnt_r   <= '0;
					end
				end
				ST_IDLE, ST_STANDBY, ST_SHUTDOWN: begin
					if (take_ctrl) begin
						state_r <= ST_ACQ;
						cnt_r   <= '0;
					end
				end
				ST_ACQ: begin
					if (ctrl_r[ACQ_BIT]) begin
						if (wr_rise) begin
							state_r <= ST_CONV;
							cnt_r   <= '0;
						end
					end else if (cnt_r == CNT_W'(ACQ_CYCLES)) begin
						state_r <= ST_CONV;
						cnt_r   <= '0;
					end else if (tick) begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				ST_CONV: begin
					if (push) begin
						cnt_r <= '0;
						case (pwr_sel)
							PWR_FULL_DOWN: state_r <= ST_SHUTDOWN;
							PWR_STANDBY:   state_r <= ST_STANDBY;
							default:       state_r <= ST_IDLE;
						endcase
					end else if (tick && cnt_r != CNT_W'(CONV_CYCLES)) begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				default: begin
					state_r <= ST_IDLE;
					cnt_r   <= '0;
				end
			endcase
		end
	end

	// sample is held at the start of conversion
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			hold_r <= '0;
		end else if (state_r == ST_ACQ && state_r != ST_CONV) begin
			hold_r <= code;
		end
	end

	// power-down states still accept bus traffic, only conversion stops
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			standby_out  <= 1'b0;
			shutdown_out <= 1'b0;
		end else begin
			standby_out  <= (state_r == ST_STANDBY);
			shutdown_out <= (state_r == ST_SHUTDOWN);
		end
	end

	// ****************************************
	// result buffer and read port
	// ****************************************
	logic                  head_valid;
	logic [RESULT_W:0]     head;
	logic                  pop;

	// the high byte read ends the pair and frees the word
	assign pop = rd_rise && hbe_s;

	result_fifo #(
		.WIDTH (RESULT_W + 1),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_sys_in    (clk_sys_in),
		.rst_in        (rst_in),
		.in_valid_in   (push),
		.in_ready_out  (fifo_ready),
		.in_data_in    ({ctrl_r[UNI_BIT], hold_r}),
		.out_valid_out (head_valid),
		.out_ready_in  (pop),
		.out_data_out  (head)
	);

	always_ff @(posedge clk_sys_in) begin
		if (rst_in || !head_valid) begin
			data_out <= '0;
		end else if (hbe_s) begin
			data_out <= {{6{!head[RESULT_W] & head[9]}}, head[9:8]};
		end else begin
			data_out <= head[7:0];
		end
	end

	assign data_oe_out = !cs_s && !rd_s;

	logic done_r;
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			done_r <= 1'b0;
		end else if (push) begin
			done_r <= 1'b1;
		end else if (rd_fall || take_ctrl) begin
			done_r <= 1'b0;
		end
	end

	assign conv_done_n_out = !done_r;
endmodule : adc_seq

// ---- tb/adc_seq_checker.sv ----
// ********
// checker
// ********
module adc_seq_checker (
	// clock and reset
	input wire logic       clk_sys_in,
	input wire logic       rst_in,
	// bus pins
	input wire logic       cs_n_in,
	input wire logic       wr_n_in,
	input wire logic       rd_n_in,
	input wire logic       data_oe_out,
	input wire logic       conv_done_n_out,
	// status
	input wire logic [2:0] pos_channel_out,
	input wire logic [2:0] neg_channel_out,
	input wire logic       neg_is_common_out,
	input wire logic       standby_out,
	input wire logic       shutdown_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	logic pwr_dn;
	logic wr_rise;
	assign pwr_dn  = standby_out || shutdown_out;
	assign wr_rise = wr_n_in && !cs_n_in;
	AST_OE_SYNC: assert property (data_oe_out == (!$past(cs_n_in, 2) && !$past(rd_n_in, 2)))
		else $error("bus drive differs from read select");
	AST_POR_IDLE: assert property ($fell(rst_in) |-> conv_done_n_out && !pwr_dn && neg_is_common_out)
		else $error("state after reset wrong");
	AST_NO_CONV: assert property (pwr_dn && $past(pwr_dn, 2) && conv_done_n_out |=> conv_done_n_out)
		else $error("result while powered down");
	AST_DONE_HOLD: assert property (cs_n_in [*5] ##0 !conv_done_n_out |=> !conv_done_n_out)
		else $error("done cleared without access");
	AST_PWR_EXCL: assert property (!(standby_out && shutdown_out))
		else $error("standby and shutdown together");
	AST_SD_AFTER: assert property ($rose(shutdown_out) |-> ##[0:2] !conv_done_n_out)
		else $error("shutdown before result");
	AST_SB_AFTER: assert property ($rose(standby_out) |-> ##[0:2] !conv_done_n_out)
		else $error("standby before result");
	AST_WAKE_SD: assert property ($rose(wr_n_in) && wr_rise && shutdown_out |-> ##[1:6] !shutdown_out)
		else $error("no wake from shutdown");
	AST_WAKE_SB: assert property ($rose(wr_n_in) && wr_rise && standby_out |-> ##[1:6] !standby_out)
		else $error("no wake from standby");
	AST_DIFF_PAIR: assert property (!neg_is_common_out |-> neg_channel_out == (pos_channel_out ^ 3'h1))
		else $error("pair mismatch");
	cover property ($rose(standby_out));
	cover property ($rose(shutdown_out));
	cover property ($fell(conv_done_n_out));
	cover property (data_oe_out);
endmodule : adc_seq_checker

bind adc_seq adc_seq_checker chk (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .cs_n_in(cs_n_in),
	.wr_n_in(wr_n_in), .rd_n_in(rd_n_in), .data_oe_out(data_oe_out), .conv_done_n_out(conv_done_n_out),
	.pos_channel_out(pos_channel_out), .neg_channel_out(neg_channel_out),
	.neg_is_common_out(neg_is_common_out), .standby_out(standby_out), .shutdown_out(shutdown_out));

// ---- tb/host_bus.sv ----
// ********
// host
// ********
module host_bus (
	input  wire logic       clk_sys_in,
	input  wire logic       data_oe_in,
	input  wire logic [7:0] dev_data_in,
	output logic            cs_n_out,
	output logic            wr_n_out,
	output logic            rd_n_out,
	output logic            high_byte_select_out,
	output logic            conv_clk_out,
	output logic [7:0]      bus_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       drv = 1'b0;
	logic [7:0] hd = 8'h00;
	logic [7:0] pat = 8'h00;
	initial begin
		cs_n_out = 1'b1;
		wr_n_out = 1'b1;
		rd_n_out = 1'b1;
		high_byte_select_out = 1'b0;
	end
	// undriven bus keeps moving, so a stale value never reads back
	always @(negedge clk_sys_in) pat <= pat + 8'h01;
	assign conv_clk_out = !cs_n_out && pat[2];
	assign bus_out = data_oe_in ? dev_data_in : drv ? hd : pat;
	task automatic put(input logic [7:0] b);
		@(negedge clk_sys_in);
		cs_n_out = 1'b0;
		drv = 1'b1;
		hd = b;
		@(negedge clk_sys_in);
		wr_n_out = 1'b0;
		repeat (4) @(negedge clk_sys_in);
		wr_n_out = 1'b1;
		repeat (4) @(negedge clk_sys_in);
		cs_n_out = 1'b1;
		drv = 1'b0;
	endtask : put
	// conversion clock only reaches the device while selected
	task automatic hold_cs(input int n);
		@(negedge clk_sys_in);
		cs_n_out = 1'b0;
		repeat (n) @(negedge clk_sys_in);
		cs_n_out = 1'b1;
	endtask : hold_cs
	task automatic get(input logic h, output logic [7:0] q);
		@(negedge clk_sys_in);
		cs_n_out = 1'b0;
		high_byte_select_out = h;
		@(negedge clk_sys_in);
		rd_n_out = 1'b0;
		repeat (4) @(negedge clk_sys_in);
		q = bus_out;
		rd_n_out = 1'b1;
		repeat (3) @(negedge clk_sys_in);
		cs_n_out = 1'b1;
	endtask : get
endmodule : host_bus

// ---- tb/tb_top.sv ----
module tb_top
	import adc_seq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic                clk_sys_in = 1'b0;
	logic                rst_in = 1'b1;
	logic                cs_n, wr_n, rd_n, hbs, cclk, oe, done_n, sb, sd, ncom;
	logic [7:0]          bus, dout;
	logic [2:0]          pos, neg;
	logic [SAMPLE_W-1:0] ain [NUM_INPUTS];
	logic [SAMPLE_W-1:0] com = 12'h010;
	logic [7:0]          dtab [4] = '{8'h81, 8'h86, 8'h89, 8'h8E};
	int                  errors = 0;
	int                  tests_run = 0;
	always #25 clk_sys_in = ~clk_sys_in;
	initial for (int i = 0; i < NUM_INPUTS; i++) ain[i] = SAMPLE_W'(12'h050 + 12'h0F1 * i);
	adc_seq dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .cs_n_in(cs_n), .wr_n_in(wr_n), .rd_n_in(rd_n),
		.high_byte_select_in(hbs), .data_in(bus), .data_out(dout), .data_oe_out(oe), .conv_done_n_out(done_n),
		.conv_clk_in(cclk), .analog_inputs_in(ain), .common_in(com), .pos_channel_out(pos),
		.neg_channel_out(neg), .neg_is_common_out(ncom), .standby_out(sb), .shutdown_out(sd));
	host_bus host (.clk_sys_in(clk_sys_in), .data_oe_in(oe), .dev_data_in(dout), .cs_n_out(cs_n),
		.wr_n_out(wr_n), .rd_n_out(rd_n), .high_byte_select_out(hbs), .conv_clk_out(cclk), .bus_out(bus));
	task automatic chk(input string s, input logic [9:0] e, input logic [9:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	function automatic logic [9:0] code(input int p, input int n, input logic u);
		int d;
		d = (p - n + 2) >>> 2;
		if (u) d = (d < 0) ? 0 : (d > 1023) ? 1023 : d;
		else d = (d < -512) ? -512 : (d > 511) ? 511 : d;
		return d[9:0];
	endfunction : code
	task automatic wait_done;
		int n;
		n = 0;
		while (done_n !== 1'b0 && n < 300) begin
			@(negedge clk_sys_in);
			n++;
		end
		chk("done", 10'h0, {9'h0, done_n});
	endtask : wait_done
	task automatic fetch(input logic [7:0] b);
		logic [7:0] lo, hi;
		logic [9:0] c;
		c = code(ain[b[2:0]], b[4] ? com : ain[b[2:0] ^ 3'h1], b[3]);
		host.get(1'b0, lo);
		chk("done clear", 10'h1, {9'h0, done_n});
		host.get(1'b1, hi);
		chk("low byte", {2'h0, c[7:0]}, {2'h0, lo});
		chk("high byte", {2'h0, {6{~b[3] & c[9]}}, c[9:8]}, {2'h0, hi});
	endtask : fetch
	task automatic conv(input logic [7:0] b);
		host.put(b);
		wait_done();
		chk("pos", {7'h0, b[2:0]}, {7'h0, pos});
		chk("common", {9'h0, b[4]}, {9'h0, ncom});
		if (!b[4]) chk("neg", {7'h0, b[2:0] ^ 3'h1}, {7'h0, neg});
		fetch(b);
	endtask : conv
	task automatic t_basic;
		chk("reset done", 10'h1, {9'h0, done_n});
		chk("reset oe", 10'h0, {9'h0, oe});
		for (int i = 0; i < 8; i++) conv(8'h98 | 8'(i));
		for (int i = 0; i < 4; i++) conv(dtab[i]);
		$display("test channels done");
	endtask : t_basic
	task automatic t_ext_clk;
		host.put(8'hDA);
		repeat (30) @(negedge clk_sys_in);
		chk("clock held", 10'h1, {9'h0, done_n});
		host.hold_cs(200);
		wait_done();
		chk("pos ext", 10'h2, {7'h0, pos});
		fetch(8'hDA);
		$display("test external clock done");
	endtask : t_ext_clk
	task automatic t_acq_ext;
		host.put(8'hB9);
		repeat (30) @(negedge clk_sys_in);
		chk("acq wait", 10'h1, {9'h0, done_n});
		host.put(8'h00);
		wait_done();
		chk("byte kept", 10'h1, {7'h0, pos});
		chk("no shutdown", 10'h0, {9'h0, sd});
		fetch(8'hB9);
		$display("test external acquisition done");
	endtask : t_acq_ext
	task automatic t_power;
		conv(8'h5A);
		chk("standby", 10'h1, {9'h0, sb});
		conv(8'h9B);
		chk("awake", 10'h0, {9'h0, sb});
		conv(8'h1C);
		chk("shutdown", 10'h1, {9'h0, sd});
		conv(8'h5D);
		chk("left shutdown", 10'h0, {9'h0, sd});
		repeat (SETTLE_EXT_CYCLES) @(negedge clk_sys_in);
		conv(8'h9D);
		chk("running", 10'h0, {9'h0, sd});
		$display("test power done");
	endtask : t_power
	task automatic t_fast;
		host.put(8'h9E);
		wait_done();
		host.put(8'h9F);
		chk("done on write", 10'h1, {9'h0, done_n});
		fetch(8'h9E);
		wait_done();
		fetch(8'h9F);
		$display("test fast done");
	endtask : t_fast
	task automatic t_fifo;
		for (int i = 0; i < FIFO_DEPTH + 1; i++) begin
			host.put(8'h9C);
			repeat (30) @(negedge clk_sys_in);
		end
		chk("full stall", 10'h1, {9'h0, done_n});
		for (int i = 0; i < FIFO_DEPTH + 1; i++) fetch(8'h9C);
		$display("test buffer done");
	endtask : t_fifo
	task automatic finish_test;
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : finish_test
	initial begin
		#1000000;
		errors++;
		$display("Error watchdog expected end seen hang");
		finish_test();
	end
	initial begin
		repeat (6) @(negedge clk_sys_in);
		rst_in = 1'b0;
		repeat (POR_CYCLES + 5) @(negedge clk_sys_in);
		t_basic();
		t_ext_clk();
		t_acq_ext();
		t_power();
		t_fast();
		t_fifo();
		finish_test();
	end
endmodule : tb_top
